// ---- hdl/cpmc_pkg.sv ----
// Purpose: shared constants and types of the privilege mode controller
// Assumes: 8-bit register port, one core command per cycle
// Notes: register indices are word addresses on the plain register port
package cpmc_pkg;
	localparam int CPMC_DW = 8;
	localparam int CPMC_AW = 4;
	localparam int CPMC_GROUPS = 16;
	localparam int CPMC_GW = 4;
	localparam int CPMC_DEPTH = 8;
	localparam int CPMC_DEPTH_W = 4;
	localparam int CPMC_VA_W = 24;
	localparam int CPMC_ST_W = 4;
	// call target that drops from system into user mode
	localparam logic [CPMC_VA_W-1:0] CPMC_USER_ENTRY_VA = 24'h800000;
	// register indices
	localparam logic [CPMC_AW-1:0] CPMC_REG_MODE = 4'h0;
	localparam logic [CPMC_AW-1:0] CPMC_REG_CFG = 4'h1;
	localparam logic [CPMC_AW-1:0] CPMC_REG_GRANT_LO = 4'h2;
	localparam logic [CPMC_AW-1:0] CPMC_REG_GRANT_HI = 4'h3;
	localparam logic [CPMC_AW-1:0] CPMC_REG_INT_STAT = 4'h4;
	localparam logic [CPMC_AW-1:0] CPMC_REG_INT_MASK = 4'h5;
	localparam logic [CPMC_AW-1:0] CPMC_REG_DEPTH = 4'h6;
	// field positions
	localparam int CPMC_MODE_SM_BIT = 0;
	localparam int CPMC_MODE_SSM_BIT = 1;
	localparam int CPMC_CFG_IRQ_SYS_BIT = 0;
	localparam int CPMC_ST_SYSTEM_VECTOR_CALL_FAULT = 0;
	localparam int CPMC_ST_RETI_FAULT = 1;
	localparam int CPMC_ST_USER_ENTRY = 2;
	localparam int CPMC_ST_STACK_OVF = 3;
	// reset values
	localparam logic CPMC_SSM_RST = 1'h1;
	localparam logic CPMC_SM_RST = 1'h0;
	localparam logic CPMC_IRQ_SYS_RST = 1'h1;
	localparam logic [CPMC_GROUPS-1:0] CPMC_GRANT_RST = 16'h0000;
	localparam logic [CPMC_ST_W-1:0] CPMC_ST_RST = 4'h0;
	localparam logic [CPMC_DW-1:0] CPMC_DENIED_RDATA = 8'h00;
	localparam logic [CPMC_DW-1:0] CPMC_UNMAPPED_RDATA = 8'h00;
	localparam logic [CPMC_DEPTH_W-1:0] CPMC_DEPTH_ZERO = 4'h0;
	localparam logic [CPMC_DEPTH_W-1:0] CPMC_DEPTH_ONE = 4'h1;
	localparam logic [CPMC_DEPTH_W-1:0] CPMC_DEPTH_FULL = 4'h8;

	typedef enum logic [2:0] {
		CPMC_CMD_NONE,
		CPMC_CMD_SYSTEM_VECTOR_CALL,
		CPMC_CMD_EXC,
		CPMC_CMD_IRQ,
		CPMC_CMD_RETI,
		CPMC_CMD_CALL
	} cpmc_cmd_t;

	// saved context of one entry event
	typedef struct packed {
		logic irq;
		logic ssm;
		logic sm;
	} cpmc_frame_t;

	function automatic logic cpmc_is_user(input logic ssm, input logic sm);
		return !ssm && !sm;
	endfunction
endpackage

// ---- hdl/cpmc_if.sv ----
// Purpose: internal carriers of the privilege mode controller
// Assumes: single clock domain
// Notes: mode stack and peripheral guard links
`timescale 1ns/100ps
interface cpmc_stack_if;
	logic push;
	logic pop;
	cpmc_pkg::cpmc_frame_t push_frame;
	cpmc_pkg::cpmc_frame_t top_frame;
	logic empty;
	logic full;
	logic [cpmc_pkg::CPMC_DEPTH_W-1:0] depth;
	modport ctrl(output push, pop, push_frame, input top_frame, empty, full, depth);
	modport store(input push, pop, push_frame, output top_frame, empty, full, depth);
endinterface

interface cpmc_guard_if;
	logic user;
	logic [cpmc_pkg::CPMC_GROUPS-1:0] grant;
	logic [cpmc_pkg::CPMC_GW-1:0] group;
	logic req;
	logic allow;
	logic [cpmc_pkg::CPMC_GROUPS-1:0] rights;
	modport ctrl(output user, grant, group, req, input allow, rights);
	modport guard(input user, grant, group, req, output allow, rights);
endinterface

// ---- hdl/cpmc_mode_stack.sv ----
// Purpose: nesting stack of saved privilege contexts
// Assumes: push and pop never in the same cycle
// Notes: a push when full is dropped; the caller flags it
`timescale 1ns/100ps
module cpmc_mode_stack (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	cpmc_stack_if.store stk
);
	cpmc_pkg::cpmc_frame_t frames [cpmc_pkg::CPMC_DEPTH];
	logic [cpmc_pkg::CPMC_DEPTH_W-1:0] depth;

	// ==========================================================
	// depth counter
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			depth <= cpmc_pkg::CPMC_DEPTH_ZERO;
		end else if (stk.push && !stk.full) begin
			depth <= depth + cpmc_pkg::CPMC_DEPTH_ONE;
		end else if (stk.pop && !stk.empty) begin
			depth <= depth - cpmc_pkg::CPMC_DEPTH_ONE;
		end
	end

	// frame storage, no reset needed: read only below depth
	always_ff @(posedge sys_clk_i) begin
		if (stk.push && !stk.full) begin
			frames[depth[cpmc_pkg::CPMC_DEPTH_W-2:0]] <= stk.push_frame;
		end
	end

	// status towards the controller
	assign stk.empty = (depth == cpmc_pkg::CPMC_DEPTH_ZERO);
	assign stk.full = (depth == cpmc_pkg::CPMC_DEPTH_FULL);
	assign stk.depth = depth;
	assign stk.top_frame = frames[3'(depth - cpmc_pkg::CPMC_DEPTH_ONE)];
endmodule // cpmc_mode_stack

// ---- hdl/cpmc_sfr_guard.sv ----
// Purpose: access rights of the peripheral register groups
// Assumes: grant vector written by system-mode code
// Notes: combinational, answers in the request cycle
`timescale 1ns/100ps
module cpmc_sfr_guard (
	cpmc_guard_if.guard gd
);
	// ==========================================================
	// per group right: full outside user mode, else grant bit
	for (genvar g = 0; g < cpmc_pkg::CPMC_GROUPS; g++) begin : g_right
		assign gd.rights[g] = !gd.user || gd.grant[g];
	end

	// a denied request is simply not allowed through
	assign gd.allow = gd.req && gd.rights[gd.group];
endmodule // cpmc_sfr_guard

// ---- hdl/cpmc_top.sv ----
// Purpose: privilege mode controller of an 8-bit secure core
// Assumes: core gives one command per cycle, inputs synchronous to sys_clk_i
// Notes: registers on a plain port, read data one cycle after the strobe
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps

// Behaviour
// - in user mode a peripheral group is usable only when system code granted it.
// - the privilege level is held in two flags, super-system and system.
// - both flags clear means the core runs in user mode.
// - a system vector call sets the system flag.
// - a system vector call outside user mode raises an exception instead.
// - every exception entry sets the system flag.
// - a system-writable setting picks whether interrupts run in user or system mode.
// - a return from an entry restores the flags saved at that entry.
// - a return in user mode needs user interrupts and an active interrupt, else it faults.
// - a call to 0x800000 in system mode switches to user mode at that address.
// - that system-to-user call pushes no return address.
// - software writes to the flags can only clear them.
// - system mode may reach every peripheral and management register.
// - no software path sets the super-system flag.
// - a register access not allowed in the current mode is ignored, reads fixed.
// - outside user mode all groups show full access.
module cpmc_top (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic [2:0] core_cmd_i,
	input wire logic [cpmc_pkg::CPMC_VA_W-1:0] call_addr_i,
	input wire logic [cpmc_pkg::CPMC_AW-1:0] reg_addr_i,
	input wire logic [cpmc_pkg::CPMC_DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [cpmc_pkg::CPMC_DW-1:0] reg_rdata_o,
	input wire logic [cpmc_pkg::CPMC_GW-1:0] periph_group_i,
	input wire logic periph_req_i,
	output logic periph_allow_o,
	output logic [cpmc_pkg::CPMC_GROUPS-1:0] group_rights_o,
	output logic super_system_flag_o,
	output logic system_level_flag_o,
	output logic user_mode_o,
	output logic exc_raise_o,
	output logic ret_push_o,
	output logic user_jump_o,
	output logic irq_o
);
	// ==========================================================
	// state
	logic super_system_flag;
	logic system_level_flag;
	logic irq_sys;
	logic [cpmc_pkg::CPMC_GROUPS-1:0] grant;
	logic [cpmc_pkg::CPMC_ST_W-1:0] int_stat;
	logic [cpmc_pkg::CPMC_ST_W-1:0] int_mask;
	logic [cpmc_pkg::CPMC_DW-1:0] rdata;
	logic exc_raise;
	logic user_jump;

	// next values and decoded events
	logic next_ssm;
	logic next_sm;
	logic mode_evt;
	logic take_exc;
	logic system_vector_call_fault;
	logic reti_fault;
	logic user_entry;
	logic stack_ovf;
	logic user;
	logic call_to_user;
	logic reti_ok;
	logic priv_wr;
	logic [cpmc_pkg::CPMC_ST_W-1:0] evt_vec;
	cpmc_pkg::cpmc_cmd_t cmd;

	cpmc_stack_if stk ();
	cpmc_guard_if gd ();

	// registers reserved for privileged code
	function automatic logic reg_guarded(input logic [cpmc_pkg::CPMC_AW-1:0] a);
		return a == cpmc_pkg::CPMC_REG_CFG || a == cpmc_pkg::CPMC_REG_GRANT_LO ||
			a == cpmc_pkg::CPMC_REG_GRANT_HI || a == cpmc_pkg::CPMC_REG_INT_STAT ||
			a == cpmc_pkg::CPMC_REG_INT_MASK;
	endfunction

	// ==========================================================
	// submodules
	cpmc_mode_stack u_stack (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.stk(stk)
	);

	cpmc_sfr_guard u_guard (
		.gd(gd)
	);

	assign gd.user = user;
	assign gd.grant = grant;
	assign gd.group = periph_group_i;
	assign gd.req = periph_req_i;

	// ==========================================================
	// mode decode
	assign cmd = cpmc_pkg::cpmc_cmd_t'(core_cmd_i);
	assign user = cpmc_pkg::cpmc_is_user(super_system_flag, system_level_flag);
	// only plain system mode may drop to user; boot code must clear ssm first
	assign call_to_user = (call_addr_i == cpmc_pkg::CPMC_USER_ENTRY_VA) &&
		system_level_flag && !super_system_flag;
	// user-mode return only from an interrupt that itself ran in user mode
	assign reti_ok = !stk.empty && (!user || (!irq_sys && stk.top_frame.irq));
	// privileged register writes; user-mode writes are dropped
	assign priv_wr = reg_wr_i && !user;

	// ==========================================================
	// mode transitions, one core command per cycle
	always_comb begin
		next_ssm = super_system_flag;
		next_sm = system_level_flag;
		mode_evt = 1'b1;
		take_exc = 1'b0;
		system_vector_call_fault = 1'b0;
		reti_fault = 1'b0;
		user_entry = 1'b0;
		stk.push = 1'b0;
		stk.pop = 1'b0;
		stk.push_frame = '{irq: 1'b0, ssm: super_system_flag, sm: system_level_flag};
		unique case (cmd)
			cpmc_pkg::CPMC_CMD_NONE: begin
				mode_evt = 1'b0;
			end
			cpmc_pkg::CPMC_CMD_SYSTEM_VECTOR_CALL: begin
				stk.push = 1'b1;
				next_sm = 1'b1;
				if (!user) begin
					system_vector_call_fault = 1'b1;
					take_exc = 1'b1;
				end
			end
			cpmc_pkg::CPMC_CMD_EXC: begin
				stk.push = 1'b1;
				next_sm = 1'b1;
				take_exc = 1'b1;
			end
			cpmc_pkg::CPMC_CMD_IRQ: begin
				stk.push = 1'b1;
				stk.push_frame.irq = 1'b1;
				if (irq_sys) begin
					next_sm = 1'b1;
				end
			end
			cpmc_pkg::CPMC_CMD_RETI: begin
				if (reti_ok) begin
					stk.pop = 1'b1;
					next_ssm = stk.top_frame.ssm;
					next_sm = stk.top_frame.sm;
				end else begin
					reti_fault = 1'b1;
					take_exc = 1'b1;
					stk.push = 1'b1;
					next_sm = 1'b1;
				end
			end
			cpmc_pkg::CPMC_CMD_CALL: begin
				if (call_to_user) begin
					next_ssm = 1'b0;
					next_sm = 1'b0;
					user_entry = 1'b1;
				end else begin
					mode_evt = 1'b0;
				end
			end
			default: begin
				mode_evt = 1'b0;
			end
		endcase
		// software may only clear; a hardware event in the same cycle wins
		if (!mode_evt && reg_wr_i && reg_addr_i == cpmc_pkg::CPMC_REG_MODE) begin
			next_ssm = super_system_flag && reg_wdata_i[cpmc_pkg::CPMC_MODE_SSM_BIT];
			next_sm = system_level_flag && reg_wdata_i[cpmc_pkg::CPMC_MODE_SM_BIT];
		end
	end

	// overflow: the context is lost, so software must hear of it
	assign stack_ovf = stk.push && stk.full;

	// ==========================================================
	// privilege flags; no path above ever sets ssm except restore
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			super_system_flag <= cpmc_pkg::CPMC_SSM_RST;
			system_level_flag <= cpmc_pkg::CPMC_SM_RST;
		end else begin
			super_system_flag <= next_ssm;
			system_level_flag <= next_sm;
		end
	end

	// ==========================================================
	// configuration, system mode only
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_sys <= cpmc_pkg::CPMC_IRQ_SYS_RST;
		end else if (priv_wr && reg_addr_i == cpmc_pkg::CPMC_REG_CFG) begin
			irq_sys <= reg_wdata_i[cpmc_pkg::CPMC_CFG_IRQ_SYS_BIT];
		end
	end

	// group grants, written byte by byte
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			grant <= cpmc_pkg::CPMC_GRANT_RST;
		end else if (priv_wr && reg_addr_i == cpmc_pkg::CPMC_REG_GRANT_LO) begin
			grant[cpmc_pkg::CPMC_DW-1:0] <= reg_wdata_i;
		end else if (priv_wr && reg_addr_i == cpmc_pkg::CPMC_REG_GRANT_HI) begin
			grant[cpmc_pkg::CPMC_GROUPS-1:cpmc_pkg::CPMC_DW] <= reg_wdata_i;
		end
	end

	// ==========================================================
	// interrupt status: sticky, write one to clear, set wins
	always_comb begin
		evt_vec = cpmc_pkg::CPMC_ST_RST;
		evt_vec[cpmc_pkg::CPMC_ST_SYSTEM_VECTOR_CALL_FAULT] = system_vector_call_fault;
		evt_vec[cpmc_pkg::CPMC_ST_RETI_FAULT] = reti_fault;
		evt_vec[cpmc_pkg::CPMC_ST_USER_ENTRY] = user_entry;
		evt_vec[cpmc_pkg::CPMC_ST_STACK_OVF] = stack_ovf;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			int_stat <= cpmc_pkg::CPMC_ST_RST;
		end else if (priv_wr && reg_addr_i == cpmc_pkg::CPMC_REG_INT_STAT) begin
			int_stat <= (int_stat & ~reg_wdata_i[cpmc_pkg::CPMC_ST_W-1:0]) | evt_vec;
		end else begin
			int_stat <= int_stat | evt_vec;
		end
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			int_mask <= cpmc_pkg::CPMC_ST_RST;
		end else if (priv_wr && reg_addr_i == cpmc_pkg::CPMC_REG_INT_MASK) begin
			int_mask <= reg_wdata_i[cpmc_pkg::CPMC_ST_W-1:0];
		end
	end

	assign irq_o = |(int_stat & int_mask);

	// ==========================================================
	// read port; guarded registers read a fixed value in user mode
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata <= cpmc_pkg::CPMC_UNMAPPED_RDATA;
		end else if (reg_rd_i && user && reg_guarded(reg_addr_i)) begin
			rdata <= cpmc_pkg::CPMC_DENIED_RDATA;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				cpmc_pkg::CPMC_REG_MODE: begin
					rdata <= {6'h00, super_system_flag, system_level_flag};
				end
				cpmc_pkg::CPMC_REG_CFG: begin
					rdata <= {7'h00, irq_sys};
				end
				cpmc_pkg::CPMC_REG_GRANT_LO: begin
					rdata <= grant[cpmc_pkg::CPMC_DW-1:0];
				end
				cpmc_pkg::CPMC_REG_GRANT_HI: begin
					rdata <= grant[cpmc_pkg::CPMC_GROUPS-1:cpmc_pkg::CPMC_DW];
				end
				cpmc_pkg::CPMC_REG_INT_STAT: begin
					rdata <= {4'h0, int_stat};
				end
				cpmc_pkg::CPMC_REG_INT_MASK: begin
					rdata <= {4'h0, int_mask};
				end
				cpmc_pkg::CPMC_REG_DEPTH: begin
					rdata <= {4'h0, stk.depth};
				end
				default: begin
					rdata <= cpmc_pkg::CPMC_UNMAPPED_RDATA;
				end
			endcase
		end else begin
			rdata <= cpmc_pkg::CPMC_UNMAPPED_RDATA; // data stands one cycle only
		end
	end

	// ==========================================================
	// core-facing pulses, registered one cycle after the command
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			exc_raise <= 1'b0;
			user_jump <= 1'b0;
		end else begin
			exc_raise <= take_exc;
			user_jump <= user_entry;
		end
	end

	// no return address for the drop to user mode
	assign ret_push_o = (cmd == cpmc_pkg::CPMC_CMD_CALL) && !call_to_user;

	// ==========================================================
	// outputs
	assign reg_rdata_o = rdata;
	assign super_system_flag_o = super_system_flag;
	assign system_level_flag_o = system_level_flag;
	assign user_mode_o = user;
	assign exc_raise_o = exc_raise;
	assign user_jump_o = user_jump;
	assign periph_allow_o = gd.allow;
	assign group_rights_o = gd.rights;
endmodule // cpmc_top

// ---- dv/cpmc_core_model.sv ----
// Purpose: core-side model that issues privilege commands
// Assumes: one command per cycle, changed just after the rising edge
// Notes: a released address shows its inverse so a stale value never passes
`timescale 1ns/100ps
module cpmc_core_model (
	input wire logic sys_clk_i,
	input wire logic ret_push_i,
	output logic [2:0] core_cmd_o,
	output logic [cpmc_pkg::CPMC_VA_W-1:0] call_addr_o,
	output logic push_seen_o
);
	// ====
	// idle values from time zero
	initial begin
		core_cmd_o = 3'h0;
		call_addr_o = 24'h000000;
		push_seen_o = 1'h0;
	end
	// one command held for one cycle; push flag caught mid-cycle, where it stands
	task automatic issue(input logic [2:0] c, input logic [23:0] a);
		@(posedge sys_clk_i);
		core_cmd_o <= c;
		call_addr_o <= a;
		@(negedge sys_clk_i);
		push_seen_o = ret_push_i;
		@(posedge sys_clk_i);
		core_cmd_o <= 3'h0;
		call_addr_o <= ~a;
	endtask
endmodule // cpmc_core_model

// ---- dv/cpmc_top_asserts.sv ----
// Purpose: port assertions of the privilege mode controller
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to cpmc_top at the foot of this file
`timescale 1ns/100ps
module cpmc_asserts (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic [2:0] core_cmd_i,
	input wire logic [cpmc_pkg::CPMC_VA_W-1:0] call_addr_i,
	input wire logic [cpmc_pkg::CPMC_AW-1:0] reg_addr_i,
	input wire logic [cpmc_pkg::CPMC_DW-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic periph_req_i,
	input wire logic periph_allow_o,
	input wire logic [cpmc_pkg::CPMC_GROUPS-1:0] group_rights_o,
	input wire logic super_system_flag_o,
	input wire logic system_level_flag_o,
	input wire logic user_mode_o,
	input wire logic exc_raise_o,
	input wire logic ret_push_o,
	input wire logic user_jump_o
);
	// ====
	// single domain, so clock and reset are given once
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!nrst_i);
	user_dec_a: assert property (user_mode_o == (!super_system_flag_o && !system_level_flag_o))
		else $error("user decode wrong");
	system_vector_call_up_a: assert property (core_cmd_i == 3'h1 && user_mode_o |=> system_level_flag_o && !exc_raise_o)
		else $error("system_vector_call from user did not enter system");
	system_vector_call_bad_a: assert property (core_cmd_i == 3'h1 && !user_mode_o |=> exc_raise_o && system_level_flag_o)
		else $error("system_vector_call outside user not refused");
	exc_sm_a: assert property (core_cmd_i == 3'h2 |=> system_level_flag_o && exc_raise_o)
		else $error("exception did not set system flag");
	drop_user_a: assert property (core_cmd_i == 3'h5 && call_addr_i == 24'h800000 && !super_system_flag_o
		&& system_level_flag_o |-> !ret_push_o ##1 user_jump_o && user_mode_o)
		else $error("call to user entry wrong");
	full_rights_a: assert property (!user_mode_o |-> group_rights_o == 16'hFFFF)
		else $error("rights not full outside user");
	sys_allow_a: assert property (!user_mode_o |-> periph_allow_o == periph_req_i)
		else $error("system access not allowed");
	ssm_rise_a: assert property ($rose(super_system_flag_o) |-> $past(core_cmd_i) == 3'h4)
		else $error("super-system flag raised by software");
	mode_clr_a: assert property (reg_wr_i && reg_addr_i == 4'h0 && core_cmd_i == 3'h0 |=>
		super_system_flag_o == ($past(super_system_flag_o) && $past(reg_wdata_i[1])))
		else $error("mode write set a flag");
endmodule // cpmc_asserts

bind cpmc_top cpmc_asserts chk_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
	.core_cmd_i(core_cmd_i), .call_addr_i(call_addr_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .periph_req_i(periph_req_i),
	.periph_allow_o(periph_allow_o), .group_rights_o(group_rights_o),
	.super_system_flag_o(super_system_flag_o), .system_level_flag_o(system_level_flag_o),
	.user_mode_o(user_mode_o), .exc_raise_o(exc_raise_o), .ret_push_o(ret_push_o),
	.user_jump_o(user_jump_o));

// ---- dv/tb_cpu_privilege_mode_control.sv ----
// Purpose: self-checking bench of the privilege mode controller
// Assumes: 200 MHz clock, reset held 10 cycles
// Notes: mode code in checks is {super-system, system, user}
`timescale 1ns/100ps
module tb_cpu_privilege_mode_control;
	logic sys_clk_i = 1'h0;
	logic nrst_i = 1'h0;
	logic [2:0] cmd;
	logic [23:0] caddr;
	logic [3:0] raddr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'h0;
	logic rd_s = 1'h0;
	logic [3:0] grp = 4'h0;
	logic preq = 1'h0;
	logic [7:0] rdata;
	logic [15:0] rights;
	logic allow, ssm, sm, user, exc, rpush, ujump, irq, seen;
	int bad_count = 0;
	int compares = 0;
	int cyc_n = 0;
	// ====
	// clock and hang guard; whole run needs about 130 cycles
	always #2.5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 3000) begin
			bad_count++;
			wrap_up();
		end
	end
	cpmc_top dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .core_cmd_i(cmd),
		.call_addr_i(caddr), .reg_addr_i(raddr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
		.reg_rd_i(rd_s), .reg_rdata_o(rdata), .periph_group_i(grp), .periph_req_i(preq),
		.periph_allow_o(allow), .group_rights_o(rights), .super_system_flag_o(ssm),
		.system_level_flag_o(sm), .user_mode_o(user), .exc_raise_o(exc),
		.ret_push_o(rpush), .user_jump_o(ujump), .irq_o(irq));
	cpmc_core_model core_u (.sys_clk_i(sys_clk_i), .ret_push_i(rpush), .core_cmd_o(cmd),
		.call_addr_o(caddr), .push_seen_o(seen));
	// ====
	// compares and bus cycles
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic chkb(input string what, input logic exp, input logic got);
		chk(what, {7'h00, exp}, {7'h00, got});
	endtask
	task automatic mode(input logic [2:0] e);
		chk("mode", {5'h00, e}, {5'h00, ssm, sm, user});
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		wr_s <= 1'h1;
		raddr <= a;
		wdata <= d;
		@(posedge sys_clk_i);
		wr_s <= 1'h0;
		wdata <= ~d;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
		@(posedge sys_clk_i);
		rd_s <= 1'h1;
		raddr <= a;
		@(posedge sys_clk_i);
		rd_s <= 1'h0;
		#1;
		chk(what, exp, rdata);
	endtask
	task automatic go(input logic [2:0] c, input logic [23:0] a);
		core_u.issue(c, a);
		#1;
	endtask
	task automatic req(input logic [3:0] g);
		@(posedge sys_clk_i);
		grp <= g;
		preq <= 1'h1;
		#1;
	endtask
	// ====
	// scenarios
	task automatic t_boot();
		mode(3'h4);
		chk("rights", 8'hFF, rights[15:8]);
		rd(4'h0, 8'h02, "mode reg");
		rd(4'h1, 8'h01, "cfg");
		rd(4'hF, 8'h00, "unmapped");
		// boot-level entry, clear ssm by software, then return: ssm comes back only by restore
		go(3'h2, 24'h000000);
		mode(3'h6);
		wr(4'h0, 8'h01);
		mode(3'h2);
		go(3'h4, 24'h000000);
		mode(3'h4);
		rd(4'h6, 8'h00, "depth boot");
		wr(4'h0, 8'h03);
		mode(3'h4);
		wr(4'h0, 8'h01);
		mode(3'h1);
		wr(4'h0, 8'h03);
		mode(3'h1);
		$display("done boot");
	endtask
	task automatic t_system_vector_call();
		go(3'h1, 24'h000000);
		mode(3'h2);
		go(3'h1, 24'h000000);
		chkb("exc system_vector_call", 1'h1, exc);
		rd(4'h4, 8'h01, "stat system_vector_call");
		wr(4'h4, 8'h01);
		go(3'h2, 24'h000000);
		chkb("exc", 1'h1, exc);
		go(3'h4, 24'h000000);
		mode(3'h2);
		go(3'h4, 24'h000000);
		go(3'h4, 24'h000000);
		mode(3'h1);
		$display("done system_vector_call");
	endtask
	task automatic t_call();
		go(3'h1, 24'h000000);
		go(3'h5, 24'h800001);
		chkb("push", 1'h1, seen);
		mode(3'h2);
		go(3'h5, 24'h800000);
		chkb("push", 1'h0, seen);
		chkb("jump", 1'h1, ujump);
		mode(3'h1);
		$display("done call");
	endtask
	task automatic t_guard();
		req(4'h3);
		chkb("allow", 1'h0, allow);
		wr(4'h2, 8'h08);
		rd(4'h2, 8'h00, "grant user");
		go(3'h1, 24'h000000);
		rd(4'h2, 8'h00, "grant sys");
		wr(4'h2, 8'h08);
		req(4'h5);
		chkb("allow", 1'h1, allow);
		go(3'h4, 24'h000000);
		req(4'h3);
		chkb("allow", 1'h1, allow);
		req(4'h4);
		chkb("allow", 1'h0, allow);
		chk("rights user", 8'h08, rights[7:0]);
		// grant now nonzero, so a denied read must still show the fixed value
		rd(4'h2, 8'h00, "grant denied");
		$display("done guard");
	endtask
	task automatic t_irq();
		go(3'h3, 24'h000000);
		mode(3'h2);
		wr(4'h1, 8'h00);
		wr(4'h5, 8'h04);
		chkb("irq", 1'h1, irq);
		wr(4'h4, 8'h04);
		chkb("irq", 1'h0, irq);
		go(3'h4, 24'h000000);
		mode(3'h1);
		go(3'h3, 24'h000000);
		mode(3'h1);
		go(3'h4, 24'h000000);
		chkb("exc reti", 1'h0, exc);
		go(3'h4, 24'h000000);
		chkb("exc reti", 1'h1, exc);
		mode(3'h2);
		rd(4'h4, 8'h02, "stat reti");
		chkb("irq masked", 1'h0, irq);
		$display("done irq");
	endtask
	// fill the nesting stack, overflow it, then unwind back to user mode
	task automatic t_ovf();
		rd(4'h6, 8'h02, "depth");
		repeat (6) go(3'h2, 24'h000000);
		rd(4'h6, 8'h08, "depth full");
		go(3'h2, 24'h000000);
		chkb("exc full", 1'h1, exc);
		rd(4'h4, 8'h0A, "stat ovf");
		go(3'h6, 24'h000000);
		mode(3'h2);
		repeat (7) go(3'h4, 24'h000000);
		mode(3'h1);
		rd(4'h6, 8'h01, "depth left");
		$display("done ovf");
	endtask
	// ====
	// verdict, reached from the main sequence or the hang guard
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (10) @(posedge sys_clk_i);
		nrst_i <= 1'h1;
		#1;
		t_boot();
		t_system_vector_call();
		t_call();
		t_guard();
		t_irq();
		t_ovf();
		wrap_up();
	end
endmodule // tb_cpu_privilege_mode_control
